// ---- verilog/pmrs_pkg.sv ----
// package for the power mode and reset sequencer
package pmrs_pkg;

	// ==========================================================
	// register map (byte offsets)
	localparam logic [11:0] PMRS_OFS_MODE   = 12'h000; // low-power target, lock, keep bits
	localparam logic [11:0] PMRS_OFS_CLKSEL = 12'h004; // system clock and clock-out select
	localparam logic [11:0] PMRS_OFS_PCLK   = 12'h008; // peripheral clock enables
	localparam logic [11:0] PMRS_OFS_BOD    = 12'h00c; // brownout levels and status
	localparam logic [11:0] PMRS_OFS_STATUS = 12'h010; // state and reset cause
	localparam logic [11:0] PMRS_OFS_PROT   = 12'h014; // protection level

	// ==========================================================
	// field positions
	localparam int PMRS_MODE_TGT_LSB  = 0;  // two bits of target
	localparam int PMRS_MODE_LOCK     = 2;
	localparam int PMRS_MODE_KEEP_WDO = 3;
	localparam int PMRS_MODE_KEEP_BOD = 4;
	localparam int PMRS_MODE_WDT_IRC  = 5;
	localparam int PMRS_NUM_PERIPH    = 16;

	// ==========================================================
	// reset values
	localparam logic [5:0]  PMRS_MODE_RST   = 6'h00;
	localparam logic [3:0]  PMRS_CLKSEL_RST = 4'h0;
	localparam logic [15:0] PMRS_PCLK_RST   = 16'hffff;
	localparam logic [4:0]  PMRS_BOD_RST    = 5'h00;

	// ==========================================================
	// reset stretch after the last source drops
	localparam int PMRS_CLK_MHZ        = 20;
	localparam int PMRS_RST_STRETCH_NS = 200;
	localparam int PMRS_RST_STRETCH_CY =
		(PMRS_RST_STRETCH_NS * PMRS_CLK_MHZ + 999) / 1000;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {
		PMRS_TGT_SLEEP = 2'h0,
		PMRS_TGT_DEEP  = 2'h1,
		PMRS_TGT_PDOWN = 2'h2,
		PMRS_TGT_DPD   = 2'h3
	} pmrs_target_type;

	typedef enum logic [1:0] {
		PMRS_SRC_IRC  = 2'h0,
		PMRS_SRC_SYSO = 2'h1,
		PMRS_SRC_WDO  = 2'h2,
		PMRS_SRC_MAIN = 2'h3
	} pmrs_src_type;

	typedef enum logic [5:0] {
		PMRS_ST_RESET  = 6'b000001,
		PMRS_ST_ACTIVE = 6'b000010,
		PMRS_ST_SLEEP  = 6'b000100,
		PMRS_ST_DEEP   = 6'b001000,
		PMRS_ST_PDOWN  = 6'b010000,
		PMRS_ST_DPD    = 6'b100000
	} pmrs_state_type;

	// clock and power gate outputs travel together
	typedef struct packed {
		logic        core_clk_en;
		logic [15:0] periph_clk_en;
		logic        internal_rc_osc_en;
		logic        internal_rc_osc_out_en;
		logic        sys_osc_en;
		logic        watchdog_osc_en;
		logic        brownout_detector_en;
		logic        analog_en;
		logic        flash_standby;
		logic        flash_off;
		logic        main_power_en;
	} pmrs_gates_type;

	// wake sources in one bundle
	typedef struct packed {
		logic gpio;
		logic wdt_irq;
		logic usb_act;
		logic any_irq;
	} pmrs_wake_type;

	// debug and boot access permits
	typedef struct packed {
		logic swd_en;
		logic jtag_bscan;
		logic boot_prog_en;
		logic boot_sector0_ok;
		logic boot_erase_only;
		logic boot_entry_pin_en;
	} pmrs_access_type;

endpackage

// ---- verilog/pmrs_sequencer.sv ----
// power mode, wake-up and reset sequencer with apb register file
// ==========================================================
// Operation
// - clock-out picks rc, system, watchdog osc or main clock
// - after power-up and deep power-down wake, system runs on the rc osc
// - four low-power states: sleep, deep, power-down, deep pd
// - one register gates each peripheral clock individually
// - sleep stops core clock only; any interrupt or reset resumes it
// - deep-sleep: only rc osc runs, its output gated unless watchdog clock
// - deep-sleep: analog off, flash standby, watchdog osc and brownout optional
// - deep and power-down wake on reset, gpio, watchdog irq, usb
// - power-down: all clocks off but selected watchdog osc, flash off
// - deep power-down: only the wake pin powered, only it or a power-on reset wakes
// - lock bit set refuses deep power-down entry
// - four reset sources each restart the rc osc and init flash
// - on reset release registers reset and core fetches address zero
// - brownout below chosen level raises irq, also readable in the brownout register
// - four selectable brownout thresholds force full chip reset
// - level one blocks debug, boot programming excludes sector zero
// - level two blocks debug, boot programming only full erase
// - level three blocks debug, boot programming and boot-entry pin
// - reset pin low selects boundary scan, high selects serial wire debug
// - serial wire debug held off while the chip is in reset
`timescale 1ns/10ps

module pmrs_sequencer
	import pmrs_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  ext_reset_n,
	input  wire logic                  watchdog_reset,
	input  wire logic                  por_detect,
	input  wire logic [3:0]            brownout_below,
	input  wire logic                  deep_wake_pin,
	input  wire logic                  core_sleep_req,
	input  wire pmrs_wake_type         wake_in,
	input  wire logic [1:0]            protect_level,
	output pmrs_gates_type             gates,
	output pmrs_src_type               clkout_sel,
	output pmrs_src_type               sysclk_sel,
	output logic                       chip_reset,
	output logic                       flash_init,
	output logic                       fetch_boot,
	output logic                       brownout_irq,
	output pmrs_access_type            access
);

	// ==========================================================
	// reset pin synchroniser, three stages
	logic [2:0] rpin_sync_r;
	logic       rpin_level_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rpin_sync_r <= 3'h0;
		else
			rpin_sync_r <= {rpin_sync_r[1:0], ext_reset_n};
	end

	// change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rpin_level_r <= 1'b0;
		else if (rpin_sync_r[1] == rpin_sync_r[2])
			rpin_level_r <= rpin_sync_r[2];
	end

	// ==========================================================
	// other async sources, three stages each
	logic [2:0] wdr_sync_r;
	logic [2:0] por_sync_r;
	logic [2:0] dwk_sync_r;
	logic [3:0] bod_s1_r;
	logic [3:0] bod_s2_r;
	logic [3:0] bod_s3_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wdr_sync_r <= 3'h0;
			por_sync_r <= 3'h7;
			dwk_sync_r <= 3'h7;
			bod_s1_r   <= 4'h0;
			bod_s2_r   <= 4'h0;
			bod_s3_r   <= 4'h0;
		end
		else
		begin
			wdr_sync_r <= {wdr_sync_r[1:0], watchdog_reset};
			por_sync_r <= {por_sync_r[1:0], por_detect};
			dwk_sync_r <= {dwk_sync_r[1:0], deep_wake_pin};
			bod_s1_r   <= brownout_below;
			bod_s2_r   <= bod_s1_r;
			bod_s3_r   <= bod_s2_r;
		end
	end

	wire wdr_hit = wdr_sync_r[1] & wdr_sync_r[2];
	wire por_hit = por_sync_r[1] & por_sync_r[2];
	// pulled-up wake pin, low wakes
	wire dwk_low = ~dwk_sync_r[1] & ~dwk_sync_r[2];

	// ==========================================================
	// registers
	logic [5:0]     mode_r;
	logic [3:0]     clksel_r;
	logic [15:0]    pclk_r;
	logic [4:0]     bod_r;      // [1:0] irq level, [3:2] reset level, [4] reset enable
	logic [3:0]     cause_r;
	pmrs_state_type state_r;
	pmrs_state_type state_nxt;
	logic           bod_irq_r;
	logic [7:0]     stretch_r;

	// threshold pick, shared by irq and reset paths
	function automatic logic below_at(input logic [3:0] lv, input logic [1:0] sel);
		below_at = lv[sel] & bod_s2_r[sel] & bod_s3_r[sel];
	endfunction

	wire bod_irq_hit = below_at(bod_s3_r, bod_r[1:0]);
	wire bod_rst_hit = bod_r[4] & below_at(bod_s3_r, bod_r[3:2]);

	wire rst_src = ~rpin_level_r | wdr_hit | por_hit | bod_rst_hit;

	// ==========================================================
	// apb slave, zero wait states
	wire apb_wr = psel & penable & pwrite;
	wire apb_rd = psel & ~pwrite & ~penable;

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == PMRS_OFS_MODE) || (a == PMRS_OFS_CLKSEL) ||
			(a == PMRS_OFS_PCLK) || (a == PMRS_OFS_BOD) ||
			(a == PMRS_OFS_STATUS) || (a == PMRS_OFS_PROT);
	endfunction

	// zero-wait ready, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r   <= PMRS_MODE_RST;
			clksel_r <= PMRS_CLKSEL_RST;
			pclk_r   <= PMRS_PCLK_RST;
			bod_r    <= PMRS_BOD_RST;
		end
		else if (chip_reset)
		begin
			mode_r   <= PMRS_MODE_RST;
			// system clock back on rc osc
			clksel_r <= PMRS_CLKSEL_RST;
			pclk_r   <= PMRS_PCLK_RST;
			bod_r    <= PMRS_BOD_RST;
		end
		else if (apb_wr)
		begin
			if (paddr == PMRS_OFS_MODE)
				mode_r <= pwdata[5:0];
			else if (paddr == PMRS_OFS_CLKSEL)
				clksel_r <= pwdata[3:0];
			else if (paddr == PMRS_OFS_PCLK)
				pclk_r <= pwdata[15:0];
			else if (paddr == PMRS_OFS_BOD)
				bod_r <= pwdata[4:0];
		end
	end

	// read data loaded at setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (apb_rd)
		begin
			if (paddr == PMRS_OFS_MODE)
				prdata <= {26'h0, mode_r};
			else if (paddr == PMRS_OFS_CLKSEL)
				prdata <= {28'h0, clksel_r};
			else if (paddr == PMRS_OFS_PCLK)
				prdata <= {16'h0, pclk_r};
			else if (paddr == PMRS_OFS_BOD)
				prdata <= {26'h0, bod_irq_r, bod_r};
			else if (paddr == PMRS_OFS_STATUS)
				prdata <= {22'h0, cause_r, state_r};
			else if (paddr == PMRS_OFS_PROT)
				prdata <= {30'h0, protect_level};
			else
				prdata <= 32'h0;
		end
	end

	// ==========================================================
	// reset stretch and cause capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stretch_r <= 8'(PMRS_RST_STRETCH_CY);
		else if (rst_src)
			stretch_r <= 8'(PMRS_RST_STRETCH_CY);
		else if (stretch_r != 8'h0)
			stretch_r <= stretch_r - 8'h1;
	end

	// sticky cause bits, cleared by por only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause_r <= 4'h0;
		else if (por_hit)
			cause_r <= 4'h1;
		else
			cause_r <= cause_r | {bod_rst_hit, wdr_hit, ~rpin_level_r, 1'b0};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bod_irq_r <= 1'b0;
		else
			bod_irq_r <= bod_irq_hit;
	end

	// ==========================================================
	// power state machine
	wire irc_for_wdt = mode_r[PMRS_MODE_WDT_IRC];
	wire keep_wdo    = mode_r[PMRS_MODE_KEEP_WDO];
	wire keep_bod    = mode_r[PMRS_MODE_KEEP_BOD];
	// wake sources for deep-sleep and power-down
	wire deep_wake   = wake_in.gpio | wake_in.wdt_irq | wake_in.usb_act;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			PMRS_ST_RESET:
				if (stretch_r == 8'h0)
					state_nxt = PMRS_ST_ACTIVE;
			PMRS_ST_ACTIVE:
				if (core_sleep_req)
				begin
					case (pmrs_target_type'(mode_r[1:0]))
						PMRS_TGT_SLEEP: state_nxt = PMRS_ST_SLEEP;
						PMRS_TGT_DEEP:  state_nxt = PMRS_ST_DEEP;
						PMRS_TGT_PDOWN: state_nxt = PMRS_ST_PDOWN;
						default:        state_nxt = mode_r[PMRS_MODE_LOCK] ?
							PMRS_ST_SLEEP : PMRS_ST_DPD;
					endcase
				end
			PMRS_ST_SLEEP:
				if (wake_in.any_irq)
					state_nxt = PMRS_ST_ACTIVE;
			PMRS_ST_DEEP:
				if (deep_wake)
					state_nxt = PMRS_ST_ACTIVE;
			PMRS_ST_PDOWN:
				if (deep_wake)
					state_nxt = PMRS_ST_ACTIVE;
			PMRS_ST_DPD:
				// the wake pin or a power-on reset returns; goes through reset
				if (dwk_low)
					state_nxt = PMRS_ST_RESET;
			default:
				state_nxt = PMRS_ST_RESET;
		endcase
		// overrides here so outputs see reset entry
		if (por_hit || (rst_src && state_r != PMRS_ST_DPD))
			state_nxt = PMRS_ST_RESET;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= PMRS_ST_RESET;
		else
			state_r <= state_nxt;
	end

	// ==========================================================
	// gate outputs from the next state
	pmrs_gates_type g_nxt;

	always_comb
	begin
		g_nxt                        = '0;
		g_nxt.main_power_en          = 1'b1;
		g_nxt.internal_rc_osc_en     = 1'b1;
		g_nxt.internal_rc_osc_out_en = 1'b1;
		g_nxt.brownout_detector_en   = 1'b1;
		case (state_nxt)
			PMRS_ST_RESET:
				g_nxt.analog_en = 1'b1;
			PMRS_ST_ACTIVE:
			begin
				g_nxt.core_clk_en     = 1'b1;
				g_nxt.periph_clk_en   = pclk_r;
				g_nxt.sys_osc_en      = 1'b1;
				g_nxt.watchdog_osc_en = 1'b1;
				g_nxt.analog_en       = 1'b1;
			end
			PMRS_ST_SLEEP:
			begin
				g_nxt.periph_clk_en   = pclk_r;
				g_nxt.sys_osc_en      = 1'b1;
				g_nxt.watchdog_osc_en = 1'b1;
				g_nxt.analog_en       = 1'b1;
			end
			PMRS_ST_DEEP:
			begin
				// rc osc output only for the watchdog
				g_nxt.internal_rc_osc_out_en = irc_for_wdt;
				g_nxt.flash_standby          = 1'b1;
				g_nxt.watchdog_osc_en        = keep_wdo;
				g_nxt.brownout_detector_en   = keep_bod;
			end
			PMRS_ST_PDOWN:
			begin
				// only selected watchdog osc, flash off
				g_nxt.internal_rc_osc_en     = 1'b0;
				g_nxt.internal_rc_osc_out_en = 1'b0;
				g_nxt.watchdog_osc_en        = keep_wdo;
				g_nxt.brownout_detector_en   = keep_bod;
				g_nxt.flash_off              = 1'b1;
			end
			default:
			begin
				g_nxt.main_power_en          = 1'b0;
				g_nxt.internal_rc_osc_en     = 1'b0;
				g_nxt.internal_rc_osc_out_en = 1'b0;
				g_nxt.brownout_detector_en   = 1'b0;
				g_nxt.flash_off              = 1'b1;
			end
		endcase
	end

	// outputs from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gates <= '0;
		else
			gates <= g_nxt;
	end

	// ==========================================================
	// clock-out and system clock selects
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clkout_sel <= PMRS_SRC_IRC;
			sysclk_sel <= PMRS_SRC_IRC;
		end
		else
		begin
			clkout_sel <= pmrs_src_type'(clksel_r[3:2]);
			sysclk_sel <= (state_nxt == PMRS_ST_RESET) ?
				PMRS_SRC_IRC : pmrs_src_type'(clksel_r[1:0]);
		end
	end

	// ==========================================================
	// reset, flash init, boot fetch and brownout irq outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chip_reset   <= 1'b1;
			flash_init   <= 1'b0;
			fetch_boot   <= 1'b0;
			brownout_irq <= 1'b0;
		end
		else
		begin
			chip_reset   <= (state_nxt == PMRS_ST_RESET);
			// flash init pulse on reset entry
			flash_init   <= (state_nxt == PMRS_ST_RESET) && (state_r != PMRS_ST_RESET);
			// fetch from address zero on release
			fetch_boot   <= (state_r == PMRS_ST_RESET) && (state_nxt == PMRS_ST_ACTIVE);
			brownout_irq <= bod_irq_r;
		end
	end

	// ==========================================================
	// debug and boot access permits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			access <= '0;
		else
		begin
			// reset pin picks the test port
			access.jtag_bscan        <= ~rpin_level_r;
			// debug off during reset; level blocks
			access.swd_en            <= rpin_level_r && (state_nxt != PMRS_ST_RESET) &&
				(protect_level == 2'h0);
			// level three blocks boot path and entry pin
			access.boot_prog_en      <= (protect_level != 2'h3);
			access.boot_entry_pin_en <= (protect_level != 2'h3);
			// sector zero kept at level one
			access.boot_sector0_ok   <= (protect_level == 2'h0);
			// full erase only at level two
			access.boot_erase_only   <= (protect_level == 2'h2);
		end
	end

endmodule

// ---- verif/pmrs_sequencer_props.sv ----
// port checks bound into the sequencer
`timescale 1ns/10ps

module pmrs_seq_chk
	import pmrs_pkg::*;
(
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic            ext_reset_n,
	input wire logic            watchdog_reset,
	input wire logic            por_detect,
	input wire pmrs_wake_type   wake_in,
	input wire logic [1:0]      protect_level,
	input wire pmrs_gates_type  gates,
	input wire pmrs_src_type    sysclk_sel,
	input wire logic            chip_reset,
	input wire logic            flash_init,
	input wire logic            fetch_boot,
	input wire pmrs_access_type access
);
	default clocking chk_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// named steps
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rst_rise_s;
		!chip_reset ##1 chip_reset;
	endsequence
	sequence rst_fall_s;
		chip_reset ##1 !chip_reset;
	endsequence
	sequence pin_low_s;
		!ext_reset_n [*4];
	endsequence

	// ==========================================================
	// bus, resets, wake and access
	chk_ready_zero_wait:
		assert property (setup_s |=> pready && penable) else $error("late bus answer");
	chk_err_with_ready:
		assert property (pslverr |-> pready) else $error("error without ready");
	chk_core_resume:
		assert property (!chip_reset && !gates.core_clk_en && gates.periph_clk_en != 16'h0
			&& wake_in.any_irq |=> gates.core_clk_en) else $error("core clock not resumed");
	chk_rc_in_reset:
		assert property (chip_reset |-> sysclk_sel == PMRS_SRC_IRC) else $error("not on rc osc");
	chk_flash_init:
		assert property (rst_rise_s |-> ##[0:1] flash_init) else $error("no flash init");
	chk_fetch_boot:
		assert property (rst_fall_s |-> ##[0:1] fetch_boot) else $error("no boot fetch");
	chk_swd_in_reset:
		assert property (chip_reset && $past(chip_reset) |-> !access.swd_en) else $error("swd on");
	chk_swd_protect:
		assert property (protect_level != 2'h0 |=> !access.swd_en) else $error("swd not blocked");
	chk_level3_boot:
		assert property (protect_level == 2'h3 |=> !access.boot_prog_en
			&& !access.boot_entry_pin_en) else $error("boot path open");
	chk_pin_jtag:
		assert property (pin_low_s |-> ##[0:3] access.jtag_bscan) else $error("no scan select");
	chk_wdt_reset:
		assert property (watchdog_reset && gates.main_power_en |-> ##[1:4] chip_reset)
			else $error("watchdog reset missed");
	chk_por_reset:
		assert property (por_detect |-> ##[1:4] chip_reset) else $error("power-on reset missed");
endmodule

bind pmrs_sequencer pmrs_seq_chk chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
	.watchdog_reset(watchdog_reset), .por_detect(por_detect), .wake_in(wake_in),
	.protect_level(protect_level), .gates(gates), .sysclk_sel(sysclk_sel),
	.chip_reset(chip_reset), .flash_init(flash_init), .fetch_boot(fetch_boot),
	.access(access)
);

// ---- verif/pmrs_core_model.sv ----
// core and wake source model facing the sequencer
`timescale 1ns/10ps

module pmrs_core_model
	import pmrs_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       core_clk_en,
	input  wire logic       wfi_cmd,
	input  wire logic [3:0] wake_cmd,
	output logic            core_sleep_req,
	output pmrs_wake_type   wake_in
);
	// ==========================================================
	// wait-for-interrupt: a halted core cannot execute it
	// sleep after config
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			core_sleep_req <= 1'h0;
		else
			core_sleep_req <= wfi_cmd && core_clk_en && !core_sleep_req;
	end

	// wake levels from peripherals
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_in <= '0;
		else
			wake_in <= pmrs_wake_type'(wake_cmd);
	end
endmodule

// ---- verif/tb_power_mode_reset_sequencer.sv ----
// self-checking bench for the sequencer
`timescale 1ns/10ps

module tb_power_mode_reset_sequencer
	import pmrs_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic        er;
	} pmrs_row_type;

	logic            pclk = 1'h0;
	logic            presetn = 1'h0;
	logic            psel = 1'h0;
	logic            penable = 1'h0;
	logic            pwrite = 1'h0;
	logic [11:0]     paddr = 12'h000;
	logic [31:0]     pwdata = 32'h0;
	logic            ext_reset_n = 1'h1;
	logic            watchdog_reset = 1'h0;
	logic            por_detect = 1'h0;
	logic [3:0]      brownout_below = 4'h0;
	logic            deep_wake_pin = 1'h1;
	logic            wfi_cmd = 1'h0;
	logic [3:0]      wake_cmd = 4'h0;
	logic [1:0]      protect_level = 2'h0;
	logic [31:0]     prdata;
	logic            pready, pslverr, core_sleep_req;
	logic            chip_reset, flash_init, fetch_boot, brownout_irq;
	pmrs_wake_type   wake_in;
	pmrs_gates_type  gates;
	pmrs_src_type    clkout_sel, sysclk_sel;
	pmrs_access_type access;
	logic [31:0]     rd;
	logic            err;
	logic            seen_init = 1'h0;
	logic            seen_boot = 1'h0;
	int              error_cnt = 0;
	int              n_compared = 0;
	int              i;

	// register rows: write if wr, read back
	pmrs_row_type rows [13] = '{
		'{1'h0, PMRS_OFS_MODE, 32'h0, 32'h0, 1'h0},
		'{1'h0, PMRS_OFS_CLKSEL, 32'h0, 32'h0, 1'h0},
		'{1'h0, PMRS_OFS_PCLK, 32'h0, 32'hffff, 1'h0},
		'{1'h0, PMRS_OFS_BOD, 32'h0, 32'h0, 1'h0},
		'{1'h0, PMRS_OFS_PROT, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h018, 32'h0, 32'h0, 1'h1},
		'{1'h1, 12'h01c, 32'hffffffff, 32'h0, 1'h1},
		'{1'h1, PMRS_OFS_PROT, 32'h3, 32'h0, 1'h0},
		'{1'h1, PMRS_OFS_MODE, 32'hffffffc0, 32'h0, 1'h0},
		'{1'h1, PMRS_OFS_PCLK, 32'hffffa5a5, 32'ha5a5, 1'h0},
		'{1'h1, PMRS_OFS_CLKSEL, 32'h5, 32'h5, 1'h0},
		'{1'h1, PMRS_OFS_CLKSEL, 32'h9, 32'h9, 1'h0},
		'{1'h1, PMRS_OFS_CLKSEL, 32'he, 32'he, 1'h0}
	};

	// ==========================================================
	// clock, design and partner
	always #25 pclk = ~pclk;

	pmrs_sequencer dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
		.watchdog_reset(watchdog_reset), .por_detect(por_detect),
		.brownout_below(brownout_below), .deep_wake_pin(deep_wake_pin),
		.core_sleep_req(core_sleep_req), .wake_in(wake_in),
		.protect_level(protect_level), .gates(gates), .clkout_sel(clkout_sel),
		.sysclk_sel(sysclk_sel), .chip_reset(chip_reset), .flash_init(flash_init),
		.fetch_boot(fetch_boot), .brownout_irq(brownout_irq), .access(access)
	);

	pmrs_core_model core_u (
		.pclk(pclk), .presetn(presetn), .core_clk_en(gates.core_clk_en),
		.wfi_cmd(wfi_cmd), .wake_cmd(wake_cmd), .core_sleep_req(core_sleep_req),
		.wake_in(wake_in)
	);

	// latch one-cycle pulses
	always @(posedge pclk)
	begin
		if (flash_init === 1'h1)
			seen_init <= 1'h1;
		if (fetch_boot === 1'h1)
			seen_boot <= 1'h1;
	end

	// ==========================================================
	// shared tasks
	task automatic tally_and_finish();
	begin
		$display("compared %0d, mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic timeout();
	begin
		error_cnt++;
		$display("[ERR] %0t wait ran out", $time);
		tally_and_finish();
	end
	endtask

	// apb transfer, held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
	begin
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
			timeout();
	end
	endtask

	// bounded wait on core clock or chip reset
	task automatic wait_sig(input logic core, input logic lvl);
		int n;
	begin
		for (n = 0; n < 100; n++)
		begin
			@(posedge pclk);
			#1;
			if ((core ? gates.core_clk_en : chip_reset) === lvl)
				return;
		end
		timeout();
	end
	endtask

	task automatic low_power(input logic [31:0] mode);
	begin
		apb(1'h1, PMRS_OFS_MODE, mode);
		@(posedge pclk);
		wfi_cmd <= 1'h1;
		@(posedge pclk);
		wfi_cmd <= 1'h0;
		wait_sig(1'h1, 1'h0);
		repeat (3) @(posedge pclk);
		#1;
	end
	endtask

	task automatic wake(input logic [3:0] src);
	begin
		@(posedge pclk);
		wake_cmd <= src;
		wait_sig(1'h1, 1'h1);
		@(posedge pclk);
		wake_cmd <= 4'h0;
	end
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (2) @(posedge pclk);
		check(chip_reset, 1'h1);
		check(access.swd_en, 1'h0);
		presetn <= 1'h1;
		wait_sig(1'h0, 1'h0);
		for (i = 0; i < 13; i++)
		begin
			if (rows[i].wr)
				apb(1'h1, rows[i].a, rows[i].d);
			apb(1'h0, rows[i].a, 32'h0);
			check(rd, rows[i].e);
			check(err, rows[i].er);
			if (rows[i].a == PMRS_OFS_CLKSEL)
				check(clkout_sel, rows[i].d[3:2]);
		end
		check(gates.periph_clk_en, 16'ha5a5);
		$display("register rows done");
		low_power(32'h0);
		check(gates.periph_clk_en, 16'ha5a5);
		apb(1'h0, PMRS_OFS_STATUS, 32'h0);
		check(rd[5:0], 6'h04);
		wake(4'h1);
		$display("sleep done");
		for (i = 0; i < 6; i++)
		begin
			low_power(32'h18 | (i < 3 ? 32'h1 : 32'h2) | (i == 0 ? 32'h20 : 32'h0));
			check(gates.periph_clk_en, 16'h0);
			check(gates.sys_osc_en, 1'h0);
			check(gates.internal_rc_osc_en, i < 3);
			check(gates.internal_rc_osc_out_en, i == 0);
			check(gates.analog_en, 1'h0);
			check(gates.brownout_detector_en, 1'h1);
			check(gates.watchdog_osc_en, 1'h1);
			check({gates.flash_standby, gates.flash_off}, i < 3 ? 2'h2 : 2'h1);
			wake(4'h8 >> (i % 3));
			check(gates.periph_clk_en, 16'ha5a5);
		end
		$display("deep states done");
		low_power(32'h7);
		check(gates.main_power_en, 1'h1);
		apb(1'h0, PMRS_OFS_STATUS, 32'h0);
		check(rd[5:0], 6'h04);
		wake(4'h1);
		$display("locked entry done");
		low_power(32'h3);
		check(gates.main_power_en, 1'h0);
		@(posedge pclk);
		wake_cmd <= 4'he;
		repeat (10) @(posedge pclk);
		#1;
		check(gates.core_clk_en, 1'h0);
		seen_boot = 1'h0;
		@(posedge pclk);
		wake_cmd <= 4'h0;
		deep_wake_pin <= 1'h0;
		wait_sig(1'h0, 1'h1);
		@(posedge pclk);
		deep_wake_pin <= 1'h1;
		wait_sig(1'h0, 1'h0);
		repeat (2) @(posedge pclk);
		#1;
		check(seen_boot, 1'h1);
		check(sysclk_sel, PMRS_SRC_IRC);
		apb(1'h0, PMRS_OFS_MODE, 32'h0);
		check(rd, 32'h0);
		$display("deep power-down done");
		for (i = 0; i < 3; i++)
		begin
			apb(1'h1, PMRS_OFS_CLKSEL, 32'h1);
			seen_init = 1'h0;
			seen_boot = 1'h0;
			@(posedge pclk);
			por_detect <= (i == 0);
			ext_reset_n <= (i != 1);
			watchdog_reset <= (i == 2);
			wait_sig(1'h0, 1'h1);
			repeat (4) @(posedge pclk);
			#1;
			check(access.jtag_bscan, i == 1);
			check(access.swd_en, 1'h0);
			@(posedge pclk);
			por_detect <= 1'h0;
			ext_reset_n <= 1'h1;
			watchdog_reset <= 1'h0;
			wait_sig(1'h0, 1'h0);
			repeat (2) @(posedge pclk);
			#1;
			check(seen_init, 1'h1);
			check(seen_boot, 1'h1);
			check(sysclk_sel, PMRS_SRC_IRC);
			apb(1'h0, PMRS_OFS_STATUS, 32'h0);
			check(rd[6 + i], 1'h1);
		end
		$display("reset sources done");
		apb(1'h1, PMRS_OFS_BOD, 32'h19);
		for (i = 1; i < 4; i++)
		begin
			@(posedge pclk);
			brownout_below <= 4'h1 << i - 1 | brownout_below;
			repeat (5) @(posedge pclk);
			#1;
			check(brownout_irq, i > 1);
			check(chip_reset, i > 2);
		end
		@(posedge pclk);
		brownout_below <= 4'h0;
		wait_sig(1'h0, 1'h0);
		apb(1'h0, PMRS_OFS_STATUS, 32'h0);
		check(rd[9], 1'h1);
		apb(1'h1, PMRS_OFS_BOD, 32'h1);
		@(posedge pclk);
		brownout_below <= 4'h3;
		repeat (5) @(posedge pclk);
		apb(1'h0, PMRS_OFS_BOD, 32'h0);
		check(rd[5], 1'h1);
		$display("brownout done");
		for (i = 0; i < 4; i++)
		begin
			@(posedge pclk);
			protect_level <= i[1:0];
			repeat (3) @(posedge pclk);
			#1;
			check(access.swd_en, i == 0);
			check(access.jtag_bscan, 1'h0);
			check(access.boot_prog_en, i != 3);
			check(access.boot_entry_pin_en, i != 3);
			if (i == 1)
				check(access.boot_sector0_ok, 1'h0);
			if (i == 2)
				check(access.boot_erase_only, 1'h1);
			apb(1'h0, PMRS_OFS_PROT, 32'h0);
			check(rd, i);
		end
		$display("protection done");
		tally_and_finish();
	end
endmodule
